// [ppad_top.sv]
// Parallel ports A to D: data and direction registers on APB, pin muxing
// with timer, serial and external-bus functions.
// Assumes synchronous pin inputs and a mode input that is steady in use.
//
// How it works
// - Direction bit 1 makes the pin an output, 0 an input, all ports.
// - Reset clears the A and D direction registers, pins high impedance.
// - Reset leaves data registers untouched; input pins stay high impedance.
// - Port A and D data registers readable and writable anytime, not reset.
// - Timer-owned port A pin stores writes but pin ignores them.
// - Serial-owned port D pin stores writes but pin ignores them.
// - Port A bits map to captures, compares and pulse accumulator.
// - Expanded or test: port B drives address 8 to 15, unmapped.
// - Single-chip or boot: port B inputs with selectable pull-ups.
// - Port B and C data registers readable and writable in single-chip or boot only, not reset.
// - Expanded or test: port C is data bus 0 to 7, unmapped.
// - Single-chip or boot: port C comes out of reset as inputs.
// - External bus is non-multiplexed: address on B, data on C.
// - Six port D pins share serial functions; top two are plain I/O.
`timescale 1ns/10ps
`default_nettype none
`include "ppad_params.svh"

module ppad_top (
   input  wire logic                   clk_i,            // Core clock, 125 MHz
   input  wire logic                   arst_n_i,         // Async reset, active low
   input  wire ppad_pkg::ppad_apb_s    apb_i,            // APB request
   output logic [31:0]                 apb_prdata_o,     // APB read data
   output logic                        apb_pready_o,     // APB ready
   output logic                        apb_pslverr_o,    // APB error
   input  wire ppad_pkg::ppad_mode_e   mode_i,           // Operating mode
   input  wire logic [7:0]             pin_a_i,          // Port A pin levels
   input  wire logic [7:0]             pin_b_i,          // Port B pin levels
   input  wire logic [7:0]             pin_c_i,          // Port C pin levels
   input  wire logic [7:0]             pin_d_i,          // Port D pin levels
   output ppad_pkg::ppad_pins_s        pin_a_o,          // Port A drive
   output ppad_pkg::ppad_pins_s        pin_b_o,          // Port B drive
   output ppad_pkg::ppad_pins_s        pin_c_o,          // Port C drive
   output ppad_pkg::ppad_pins_s        pin_d_o,          // Port D drive
   input  wire logic [7:0]             timer_own_i,      // Timer owns port A bit
   input  wire logic [7:0]             timer_out_i,      // Timer output levels
   input  wire logic [7:0]             timer_oe_i,       // Timer output enables
   output logic [7:0]                  timer_pin_o,      // Port A levels to timer
   input  wire logic [5:0]             serial_own_i,     // Serial owns port D bit
   input  wire logic [5:0]             serial_out_i,     // Serial output levels
   input  wire logic [5:0]             serial_oe_i,      // Serial output enables
   output logic [5:0]                  serial_pin_o,     // Port D levels to serial
   input  wire logic [7:0]             ext_addr_hi_i,    // External address 15:8
   input  wire logic [7:0]             ext_data_i,       // External write data
   input  wire logic                   ext_data_drive_i, // Drive data bus out
   output logic [7:0]                  ext_data_o,       // Data bus levels
   output logic                        ext_cycle_o,      // Fall-through access pulse
   input  wire logic                   pullup_b_sel_i,   // Pull-up select, port B
   output logic                        pullup_b_o        // Port B pull-ups enabled
);

   // Register state
   logic [7:0]         a_data_q;
   logic [7:0]         b_data_q;
   logic [7:0]         c_data_q;
   logic [7:0]         d_data_q;
   logic [7:0]         a_dir_q;
   logic [7:0]         b_dir_q;
   logic [7:0]         c_dir_q;
   logic [7:0]         d_dir_q;

   // Bus side
   logic [3:0]         idx;
   ppad_pkg::ppad_wr_s wr;
   logic               expanded;
   logic               idx_bc;
   logic               hit;
   logic               fall;
   logic [7:0]         rdata;

   // Pin mux inputs
   logic [7:0]         d_own;
   logic [7:0]         d_alt_o;
   logic [7:0]         d_alt_oe;
   logic [7:0]         bus_own;
   logic [7:0]         c_alt_oe;

   // Read value: latched bit where driven out, pin level where input
   function automatic logic [7:0] rd_mix(input logic [7:0] dir, input logic [7:0] data,
                                         input logic [7:0] pin);
      rd_mix = (dir & data) | (~dir & pin);
   endfunction

   // Mode decode; expanded and test both carry the external bus
   assign expanded = (mode_i == ppad_pkg::PPAD_EXPANDED) || (mode_i == ppad_pkg::PPAD_TEST);
   assign bus_own  = {8{expanded}};

   // Ports B and C leave the map in bus modes and fall through instead
   assign idx_bc = (idx == `PPAD_IDX_B_DIR)  || (idx == `PPAD_IDX_B_DATA) ||
                   (idx == `PPAD_IDX_C_DATA) || (idx == `PPAD_IDX_C_DIR);
   assign fall   = expanded && idx_bc;
   assign hit    = !fall && ((idx == `PPAD_IDX_A_DATA) || (idx == `PPAD_IDX_A_DIR) ||
                             idx_bc || (idx == `PPAD_IDX_D_DATA) || (idx == `PPAD_IDX_D_DIR));

   // Read selection; fall-through reads return the external data bus
   assign rdata = fall                          ? pin_c_i :
                  (idx == `PPAD_IDX_A_DATA)     ? rd_mix(a_dir_q, a_data_q, pin_a_i) :
                  (idx == `PPAD_IDX_A_DIR)      ? a_dir_q :
                  (idx == `PPAD_IDX_B_DIR)      ? b_dir_q :
                  (idx == `PPAD_IDX_B_DATA)     ? rd_mix(b_dir_q, b_data_q, pin_b_i) :
                  (idx == `PPAD_IDX_C_DATA)     ? rd_mix(c_dir_q, c_data_q, pin_c_i) :
                  (idx == `PPAD_IDX_C_DIR)      ? c_dir_q :
                  (idx == `PPAD_IDX_D_DATA)     ? rd_mix(d_dir_q, d_data_q, pin_d_i) :
                  (idx == `PPAD_IDX_D_DIR)      ? d_dir_q : 8'h00;

   // Bus front end
   ppad_apb u_apb (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .req_i     (apb_i),
      .rdata_i   (rdata),
      .hit_i     (hit),
      .fall_i    (fall),
      .idx_o     (idx),
      .wr_o      (wr),
      .prdata_o  (apb_prdata_o),
      .pready_o  (apb_pready_o),
      .pslverr_o (apb_pslverr_o),
      .ext_o     (ext_cycle_o)
   );

   // Data registers carry no reset: contents survive reset unchanged
   always_ff @(posedge clk_i) begin
      if (wr.en && (wr.idx == `PPAD_IDX_A_DATA)) a_data_q <= wr.data;
      if (wr.en && (wr.idx == `PPAD_IDX_B_DATA)) b_data_q <= wr.data;
      if (wr.en && (wr.idx == `PPAD_IDX_C_DATA)) c_data_q <= wr.data;
      if (wr.en && (wr.idx == `PPAD_IDX_D_DATA)) d_data_q <= wr.data;
   end

   // Direction registers clear on reset so every pin not owned by the bus or an alternate function starts as input
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         a_dir_q <= `PPAD_DIR_RST;
         b_dir_q <= `PPAD_DIR_RST;
         c_dir_q <= `PPAD_DIR_RST;
         d_dir_q <= `PPAD_DIR_RST;
      end else begin
         if (wr.en && (wr.idx == `PPAD_IDX_A_DIR)) a_dir_q <= wr.data;
         if (wr.en && (wr.idx == `PPAD_IDX_B_DIR)) b_dir_q <= wr.data;
         if (wr.en && (wr.idx == `PPAD_IDX_C_DIR)) c_dir_q <= wr.data;
         if (wr.en && (wr.idx == `PPAD_IDX_D_DIR)) d_dir_q <= wr.data;
      end
   end

   // Port A: bits 0-2 captures 3,2,1; bit 3 compare 5/1 or capture 4;
   // bits 4-6 compares 4,3,2 with compare 1; bit 7 accumulator input
   ppad_pin u_pin_a (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .data_i   (a_data_q),
      .dir_i    (a_dir_q),
      .own_i    (timer_own_i),
      .alt_o_i  (timer_out_i),
      .alt_oe_i (timer_oe_i),
      .pins_o   (pin_a_o)
   );

   // Port B: high address 15:8 in bus modes, always driven there
   ppad_pin u_pin_b (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .data_i   (b_data_q),
      .dir_i    (b_dir_q),
      .own_i    (bus_own),
      .alt_o_i  (ext_addr_hi_i),
      .alt_oe_i (8'hFF),
      .pins_o   (pin_b_o)
   );

   // Port C: data bus 7:0, direction set by the bus cycle
   assign c_alt_oe = {8{ext_data_drive_i}};
   ppad_pin u_pin_c (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .data_i   (c_data_q),
      .dir_i    (c_dir_q),
      .own_i    (bus_own),
      .alt_o_i  (ext_data_i),
      .alt_oe_i (c_alt_oe),
      .pins_o   (pin_c_o)
   );

   // Port D: only bits 5:0 can be taken by the serial blocks
   assign d_own    = {2'b00, serial_own_i};
   assign d_alt_o  = {2'b00, serial_out_i};
   assign d_alt_oe = {2'b00, serial_oe_i};
   ppad_pin u_pin_d (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .data_i   (d_data_q),
      .dir_i    (d_dir_q),
      .own_i    (d_own),
      .alt_o_i  (d_alt_o),
      .alt_oe_i (d_alt_oe),
      .pins_o   (pin_d_o)
   );

   // Pin levels handed to on-chip functions, registered for clean outputs
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_pin_o  <= 8'h00;
         serial_pin_o <= 6'h00;
         ext_data_o   <= 8'h00;
         pullup_b_o   <= 1'b0;
      end else begin
         timer_pin_o  <= pin_a_i;
         serial_pin_o <= pin_d_i[`PPAD_SER_W-1:0];
         ext_data_o   <= pin_c_i;
         pullup_b_o   <= pullup_b_sel_i && !expanded;
      end
   end

   // Helper for checks: marks the first cycle after reset release
   logic first_q;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) first_q <= 1'b1;
      else           first_q <= 1'b0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   AST_DIR_RESET: assert property (first_q |-> (pin_a_o.oe == 8'h00) && (pin_d_o.oe == 8'h00)
                                   && (a_dir_q == 8'h00) && (d_dir_q == 8'h00))
      else $error("direction or drive not clear after reset");

   AST_DIR_WRITE: assert property ((wr.en && wr.idx == `PPAD_IDX_A_DIR) |=> ##1
                                   ((pin_a_o.oe & ~$past(timer_own_i)) == ($past(wr.data, 2) & ~$past(timer_own_i))))
      else $error("port A enable does not follow direction write");

   // The first edge after release still loads the reset drive, so it is skipped
   AST_A_ALT_PIN: assert property ((timer_own_i[0] && !first_q) |=> (pin_a_o.o[0] == $past(timer_out_i[0]))
                                   && (pin_a_o.oe[0] == $past(timer_oe_i[0])))
      else $error("timer-owned pin not driven by timer");

   AST_D_ALT_PIN: assert property ((serial_own_i[2] && !first_q) |=> (pin_d_o.o[2] == $past(serial_out_i[2])))
      else $error("serial-owned pin not driven by serial");

   AST_D_TOP_GPIO: assert property ((wr.en && wr.idx == `PPAD_IDX_D_DIR) |=> ##1
                                    (pin_d_o.oe[7:6] == $past(wr.data[7:6], 2)))
      else $error("port D top bits not plain I/O");

   AST_B_ADDR: assert property (expanded |=> (pin_b_o.oe == 8'hFF) && (pin_b_o.o == $past(ext_addr_hi_i)))
      else $error("port B not driving high address");

   AST_C_DATA: assert property (expanded |=> (pin_c_o.oe == {8{$past(ext_data_drive_i)}}))
      else $error("port C not following data bus direction");

   AST_FALL_THROUGH: assert property ((apb_i.psel && !apb_i.penable && !apb_pready_o && fall
                                       && apb_i.paddr[1:0] == 2'h0 && apb_i.paddr[11:6] == 6'h00)
                                      |=> ext_cycle_o && apb_pready_o && !apb_pslverr_o)
      else $error("unmapped port access did not fall through");

   AST_READ_MIX: assert property ((apb_i.psel && !apb_i.penable && !apb_pready_o && !apb_i.pwrite
                                   && apb_i.paddr == 12'h000 && a_dir_q == 8'hFF)
                                  |=> apb_prdata_o[7:0] == $past(a_data_q))
      else $error("output pin read did not return latch");

   CVR_DIR_WRITE: cover property (wr.en && wr.idx == `PPAD_IDX_A_DIR);
   CVR_EXT_CYCLE: cover property (ext_cycle_o);
   CVR_ERR:       cover property (apb_pslverr_o && apb_pready_o);
   CVR_ALT_WRITE: cover property (wr.en && wr.idx == `PPAD_IDX_D_DATA && serial_own_i != 6'h00);

endmodule // ppad_top

`default_nettype wire

// [ppad_params.svh]
// Register indices, byte addresses and reset values for ports A to D.
// Assumes inclusion by every file that decodes the register map.
`ifndef PPAD_PARAMS_SVH
`define PPAD_PARAMS_SVH

// Register indices; the byte address is four times the index
`define PPAD_IDX_A_DATA  4'h0
`define PPAD_IDX_A_DIR   4'h1
`define PPAD_IDX_B_DIR   4'h2
`define PPAD_IDX_B_DATA  4'h4
`define PPAD_IDX_C_DATA  4'h6
`define PPAD_IDX_C_DIR   4'h7
`define PPAD_IDX_D_DATA  4'h8
`define PPAD_IDX_D_DIR   4'h9

// Address layout: index in bits 5:2, low two bits must be zero or the access errors
`define PPAD_ADDR_W      12
`define PPAD_IDX_LSB     2
`define PPAD_IDX_MSB     5

// Reset value of every direction register
`define PPAD_DIR_RST     8'h00

// Width of the serial-shared group of port D
`define PPAD_SER_W       6

`endif

// [ppad_pkg.sv]
// Types shared by the port A to D block.
// Assumes ppad_params.svh for the address width.
`include "ppad_params.svh"

package ppad_pkg;

   // Operating mode of the device
   typedef enum logic [1:0] {
      PPAD_SINGLE,
      PPAD_BOOT,
      PPAD_EXPANDED,
      PPAD_TEST
   } ppad_mode_e;

   // APB request from the master
   typedef struct packed {
      logic                      psel;
      logic                      penable;
      logic                      pwrite;
      logic [`PPAD_ADDR_W-1:0]   paddr;
      logic [31:0]               pwdata;
   } ppad_apb_s;

   // One 8-bit pin group: output level and output enable
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } ppad_pins_s;

   // Register write strobe with index and byte
   typedef struct packed {
      logic       en;
      logic [3:0] idx;
      logic [7:0] data;
   } ppad_wr_s;

endpackage

// [ppad_apb.sv]
// APB slave front end: index decode, zero-wait answer and write strobe.
// Assumes the parent supplies read data and the hit flag for idx_o.
`timescale 1ns/10ps
`default_nettype none
`include "ppad_params.svh"

module ppad_apb (
   input  wire logic               clk_i,      // Core clock
   input  wire logic               arst_n_i,   // Async reset, active low
   input  wire ppad_pkg::ppad_apb_s req_i,     // APB request
   input  wire logic [7:0]         rdata_i,    // Read value at idx_o
   input  wire logic               hit_i,      // idx_o is mapped
   input  wire logic               fall_i,     // idx_o falls to external bus
   output logic [3:0]              idx_o,      // Decoded index
   output ppad_pkg::ppad_wr_s      wr_o,       // Write strobe
   output logic [31:0]             prdata_o,   // Registered read data
   output logic                    pready_o,   // Registered ready
   output logic                    pslverr_o,  // Registered error
   output logic                    ext_o       // Fall-through pulse
);

   logic        setup;
   logic        aligned;
   logic        ok;
   logic        done;

   // Decode; unaligned or out-of-range addresses are errors
   assign idx_o   = req_i.paddr[`PPAD_IDX_MSB:`PPAD_IDX_LSB];
   assign aligned = (req_i.paddr[1:0] == 2'h0) && (req_i.paddr[`PPAD_ADDR_W-1:6] == '0);
   assign ok      = aligned && (hit_i || fall_i);
   assign setup   = req_i.psel && !req_i.penable && !pready_o;
   assign done    = req_i.psel && req_i.penable && pready_o;

   // Writes land only on the edge that completes the access
   assign wr_o.en   = done && req_i.pwrite && aligned && hit_i;
   assign wr_o.idx  = idx_o;
   assign wr_o.data = req_i.pwdata[7:0];

   // Answer is prepared in setup so every answer output leaves a flop
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         ext_o     <= 1'b0;
      end else begin
         pready_o  <= setup;
         pslverr_o <= setup && !ok;
         prdata_o  <= (setup && !req_i.pwrite && ok) ? {24'h00_0000, rdata_i} : 32'h0000_0000;
         ext_o     <= setup && aligned && fall_i;
      end
   end

endmodule // ppad_apb

`default_nettype wire

// [ppad_pin.sv]
// Pin stage for one 8-bit port: mux between port logic and alternate owner.
// Assumes alternate inputs are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module ppad_pin (
   input  wire logic        clk_i,     // Core clock
   input  wire logic        arst_n_i,  // Async reset, active low
   input  wire logic [7:0]  data_i,    // Port data register
   input  wire logic [7:0]  dir_i,     // Direction register, 1 = output
   input  wire logic [7:0]  own_i,     // Alternate function owns the pin
   input  wire logic [7:0]  alt_o_i,   // Alternate output level
   input  wire logic [7:0]  alt_oe_i,  // Alternate output enable
   output ppad_pkg::ppad_pins_s pins_o // Registered pin drive
);

   logic [7:0] o_d;
   logic [7:0] oe_d;

   // An owned pin ignores the data register, so writes still store only
   assign o_d  = (own_i & alt_o_i) | (~own_i & data_i);
   assign oe_d = (own_i & alt_oe_i) | (~own_i & dir_i);

   // Drivers come up off so every pin starts high impedance
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pins_o <= '0;
      end else begin
         pins_o.o  <= o_d;
         pins_o.oe <= oe_d;
      end
   end

endmodule // ppad_pin

`default_nettype wire

// [ppad_pin_model.sv]
// Far end of one 8-bit pin group: resolves the wire level.
// Assumes the bench sets the far-end level and holds it steady.
`timescale 1ns/10ps
`default_nettype none

module ppad_pin_model (
   input  wire ppad_pkg::ppad_pins_s pins_i, // Drive from the block
   input  wire logic [7:0]           far_i,  // Level set by the far end
   output logic [7:0]                lvl_o   // Resolved wire level
);
   // A driven bit follows the block; a floating bit shows the far end
   assign lvl_o = (pins_i.oe & pins_i.o) | (~pins_i.oe & far_i);
endmodule // ppad_pin_model

`default_nettype wire

// [tb_top.sv]
// Bench for ports A to D: APB master, pin far ends, timer and serial owners.
// Assumes ppad_pkg, ppad_top and ppad_pin_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "ppad_params.svh"

module tb_top;
   logic                 clk_i, arst_n_i, pready, perr, err, ext_drv, ext_cyc, pull_sel, pull_o;
   ppad_pkg::ppad_apb_s  apb;
   ppad_pkg::ppad_mode_e mode;
   ppad_pkg::ppad_pins_s pins [4];
   logic [31:0]          prdata, rd;
   logic [7:0]           far [4], lvl [4], lat [4], dr [4];
   logic [7:0]           t_own, t_out, t_oe, t_pin, ext_addr, ext_data, ext_o;
   logic [5:0]           s_own, s_out, s_oe, s_pin;
   int                   num_errors, check_count, ext_cnt, seed, p, n0;
   localparam logic [3:0] DAT [4] = '{`PPAD_IDX_A_DATA, `PPAD_IDX_B_DATA, `PPAD_IDX_C_DATA, `PPAD_IDX_D_DATA};
   localparam logic [3:0] DIR [4] = '{`PPAD_IDX_A_DIR, `PPAD_IDX_B_DIR, `PPAD_IDX_C_DIR, `PPAD_IDX_D_DIR};
   localparam logic [11:0] BAD [5] = '{12'h00C, 12'h014, 12'h028, 12'h001, 12'h040};

   ppad_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .apb_i(apb), .apb_prdata_o(prdata), .apb_pready_o(pready),
      .apb_pslverr_o(perr), .mode_i(mode), .pin_a_i(lvl[0]), .pin_b_i(lvl[1]), .pin_c_i(lvl[2]), .pin_d_i(lvl[3]),
      .pin_a_o(pins[0]), .pin_b_o(pins[1]), .pin_c_o(pins[2]), .pin_d_o(pins[3]), .timer_own_i(t_own),
      .timer_out_i(t_out), .timer_oe_i(t_oe), .timer_pin_o(t_pin), .serial_own_i(s_own), .serial_out_i(s_out),
      .serial_oe_i(s_oe), .serial_pin_o(s_pin), .ext_addr_hi_i(ext_addr), .ext_data_i(ext_data),
      .ext_data_drive_i(ext_drv), .ext_data_o(ext_o), .ext_cycle_o(ext_cyc), .pullup_b_sel_i(pull_sel),
      .pullup_b_o(pull_o));

   // One far-end model per pin group
   for (genvar g = 0; g < 4; g++) begin : g_far
      ppad_pin_model i_pm (.pins_i(pins[g]), .far_i(far[g]), .lvl_o(lvl[g]));
   end

   // Free-running core clock, 8 ns period
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Pulses are counted, since their exact cycle is the design's choice
   always @(posedge clk_i) if (ext_cyc === 1'b1) ext_cnt <= ext_cnt + 1;

   function automatic logic is_ext();
      return mode == ppad_pkg::PPAD_EXPANDED || mode == ppad_pkg::PPAD_TEST;
   endfunction

   // Expected drive of group q from shadow registers and owners
   function automatic ppad_pkg::ppad_pins_s exp_pins(input int q);
      logic [7:0] own, ao, aoe;
      own = (q == 0) ? t_own : (q == 3) ? {2'h0, s_own} : 8'h00;
      ao = (q == 0) ? t_out : {2'h0, s_out};
      aoe = (q == 0) ? t_oe : {2'h0, s_oe};
      exp_pins.o = (own & ao) | (~own & lat[q]);
      exp_pins.oe = (own & aoe) | (~own & dr[q]);
      if (is_ext() && q == 1) exp_pins = '{ext_addr, 8'hFF};
      if (is_ext() && q == 2) exp_pins = '{ext_data, {8{ext_drv}}};
   endfunction

   function automatic logic [7:0] exp_lvl(input int q);
      ppad_pkg::ppad_pins_s e;
      e = exp_pins(q);
      return (e.oe & e.o) | (~e.oe & far[q]);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      apb <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
      @(posedge clk_i);
      apb.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = perr;
      if (n >= 20) chk(32'h0, 32'h1, "no ready");
      apb <= '0;
   endtask

   // Writes in bus mode to B or C are dropped, so the shadow stays
   task automatic put(input int q, input logic is_dir, input logic [7:0] d);
      xfer(1'b1, {6'h0, is_dir ? DIR[q] : DAT[q], 2'h0}, d);
      if (!is_ext() || q == 0 || q == 3) begin
         if (is_dir) dr[q] = d;
         else lat[q] = d;
      end
   endtask

   task automatic rdchk(input int q);
      logic [7:0] e;
      e = (is_ext() && (q == 1 || q == 2)) ? exp_lvl(2) : (dr[q] & lat[q]) | (~dr[q] & exp_lvl(q));
      xfer(1'b0, {6'h0, DAT[q], 2'h0}, 8'h00);
      chk(rd, {24'h0, e}, "data read");
      chk(32'(err), 32'h0, "data error");
   endtask

   // Let pins settle, then compare every group and the owner feedback
   task automatic look();
      ppad_pkg::ppad_pins_s e;
      logic [7:0] d;
      repeat (3) @(posedge clk_i);
      for (int q = 0; q < 4; q++) begin
         e = exp_pins(q);
         chk({16'h0, pins[q].oe, pins[q].o & pins[q].oe}, {16'h0, e.oe, e.o & e.oe}, "pins");
      end
      d = exp_lvl(3);
      chk(32'(t_pin), 32'(exp_lvl(0)), "timer levels");
      chk(32'(s_pin), 32'(d[5:0]), "serial levels");
      chk(32'(pull_o), 32'(pull_sel & !is_ext()), "pull-up select");
   endtask

   task automatic shake();
      t_own <= 8'($random(seed));
      t_out <= 8'($random(seed));
      t_oe <= 8'($random(seed));
      s_own <= 6'($random(seed));
      s_out <= 6'($random(seed));
      s_oe <= 6'($random(seed));
      pull_sel <= 1'($random(seed));
      for (int q = 0; q < 4; q++) far[q] <= 8'($random(seed));
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 600 cycles
   initial begin
      #100000;
      num_errors++;
      give_verdict();
   end

   // Main sequence
   initial begin
      seed = 32'hbea86417;
      {num_errors, check_count} = '0;
      {arst_n_i, apb, ext_addr, ext_data, ext_drv, t_own, t_out, t_oe, s_own, s_out, s_oe} = '0;
      mode = ppad_pkg::PPAD_SINGLE;
      pull_sel = 1'b1;
      for (int q = 0; q < 4; q++) {far[q], dr[q], lat[q]} = {8'($random(seed)), 8'h00, 8'hXX};
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      look();
      chk(32'(pull_o), 32'h1, "pull-up");
      for (int q = 0; q < 4; q++) begin
         xfer(1'b0, {6'h0, DIR[q], 2'h0}, 8'h00);
         chk(rd, 32'h0, "dir reset");
         put(q, 1'b0, 8'($random(seed)));
      end
      // Random owners, far levels and register contents
      repeat (40) begin
         p = {$random(seed)} % 4;
         mode <= ($random(seed) & 1) ? ppad_pkg::PPAD_BOOT : ppad_pkg::PPAD_SINGLE;
         shake();
         put(p, 1'b0, 8'($random(seed)));
         put(p, 1'b1, 8'($random(seed)));
         look();
         rdchk(p);
      end
      // Reset in mid-run: directions clear, data stays
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      for (int q = 0; q < 4; q++) dr[q] = 8'h00;
      look();
      for (int q = 0; q < 4; q++) begin
         put(q, 1'b1, 8'hFF);
         rdchk(q);
      end
      // Unmapped and unaligned addresses are refused
      foreach (BAD[i]) begin
         xfer(1'(i & 1), BAD[i], 8'hA5);
         chk({rd[30:0], err}, 32'h1, "refusal");
      end
      // Bus modes: B carries address, C carries data, B unmapped
      for (int m = 2; m < 4; m++) begin
         mode <= ppad_pkg::ppad_mode_e'(m);
         ext_addr <= 8'($random(seed));
         ext_data <= 8'($random(seed));
         ext_drv <= 1'($random(seed));
         look();
         chk(32'(pull_o), 32'h0, "pull-up bus mode");
         chk(32'(ext_o), 32'(exp_lvl(2)), "data bus in");
         n0 = ext_cnt;
         put(1, 1'b0, ~lat[1]);
         rdchk(1);
         repeat (2) @(posedge clk_i);
         chk(ext_cnt - n0, 32'h2, "fall-through");
      end
      mode <= ppad_pkg::PPAD_SINGLE;
      look();
      n0 = ext_cnt;
      rdchk(1);
      rdchk(2);
      repeat (2) @(posedge clk_i);
      chk(ext_cnt - n0, 32'h0, "no fall-through");
      give_verdict();
   end
endmodule // tb_top

`default_nettype wire
